// ===== tlic_ctrl.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "tlic_params.svh"
// How it works
// - Each peripheral source has flag, enable, priority; pin-zero source has flag and enable only and is always high.
// - With priority on, high goes to 0008h, low to 0018h.
// - High request preempts a low service already running.
// - Twenty-one visible registers: three control, five flag, five enable, five priority, reset control, status, mask.
// - Enable lets a set flag branch; priority bit picks level.
// - Scheme enable clear by default; priority bits then ignored.
// - Compatibility: peripheral enable gates only peripherals, needs global enable too.
// - Compatibility: global enable allows non-peripherals; clear blocks everything.
// - Compatibility: every accepted interrupt vectors to 0008h.
// - Scheme enable in reset control splits globals into high and low.
// - Priority on: high global allows high sources; clear blocks all.
// - Priority on: low global gates low sources, only with high global set.
// - Flag, enable and global all set: vector at once. Here a request waits while a service of the same or a higher level runs.
// - Accepting an interrupt clears the global enable of that level.
// - Low requests wait while a high service runs.
// - Flags set on events regardless of any enable.
// - Return instruction sets the global enable of the level again.
module tlic_ctrl #(
    parameter int NSRC = 8 * `TLIC_BANKS
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    resetn_in,
    input  wire logic [`TLIC_ADDR_W-1:0] addr_in,
    input  wire logic [7:0]              wdata_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic      [7:0]              rdata_out,
    input  wire logic                    ext0_pin_in,
    input  wire logic [NSRC-1:0]         periph_event_in,
    input  wire logic                    vec_ack_in,
    input  wire logic                    retirq_in,
    output logic                         vec_req_out,
    output logic      [15:0]             vec_addr_out,
    output logic                         irq_out
);
    localparam int NB = `TLIC_BANKS;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       ctrl0;
        logic [7:0]       ctrl1;
        logic [7:0]       ctrl2;
        logic [NB*8-1:0]  flag;
        logic [NB*8-1:0]  ena;
        logic [NB*8-1:0]  prio;
        logic [7:0]       rstctl;
        logic [1:0]       stat;
        logic [1:0]       mask;
        logic             ext0_prev;
        tlic_pkg::tlic_svc_t svc;
        logic             lo_hold;     // A high service has cut into a low one
        logic             req;
        logic             req_high;
        logic [15:0]      vec;
        logic [7:0]       rdata;
    } tlic_state_t;

    tlic_state_t r_q;
    tlic_state_t r_d;

    logic ext0_s;

    // Pin event passes two flops before use
    tlic_sync #(
        .W (1)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .async_in   (ext0_pin_in),
        .sync_out   (ext0_s)
    );

    // Reduce one flag/enable pair set to a pending indication
    function automatic logic any_pend(input logic [NB*8-1:0] f,
                                      input logic [NB*8-1:0] e,
                                      input logic [NB*8-1:0] sel);
        any_pend = |(f & e & sel);
    endfunction

    // Hit on the index of bank b inside one of the five-register groups
    function automatic logic bank_hit(input logic [`TLIC_ADDR_W-1:0] a,
                                      input logic [`TLIC_ADDR_W-1:0] base,
                                      input int                      b);
        bank_hit = (a == base + 5'(b));
    endfunction

    // ------------------------------------------------------------
    // Eligibility
    // ------------------------------------------------------------
    logic pse;
    logic geh;
    logic pel;
    logic ext0_pend;
    logic per_hi;
    logic per_lo;
    logic elig_hi;
    logic elig_lo;
    logic [NB*8-1:0] prio_eff;

    // Priority bits count only while the scheme is on; otherwise all look high
    always_comb begin
        pse       = r_q.rstctl[`TLIC_BIT_PSE];
        geh       = r_q.ctrl0[`TLIC_BIT_GEH];
        pel       = r_q.ctrl0[`TLIC_BIT_PEL];
        prio_eff  = pse ? r_q.prio : '1;
        // Pin-zero has no priority bit and only ever joins the high side
        ext0_pend = r_q.ctrl0[`TLIC_BIT_EXT0_FLAG] & r_q.ctrl0[`TLIC_BIT_EXT0_EN];
        per_hi    = any_pend(r_q.flag, r_q.ena, prio_eff);
        per_lo    = any_pend(r_q.flag, r_q.ena, ~prio_eff);
        if (!pse) begin
            // Compatibility: one level, peripherals need both globals
            elig_hi = geh & (ext0_pend | (pel & per_hi));
            elig_lo = 1'b0;
        end else begin
            elig_hi = geh & (ext0_pend | per_hi);
            elig_lo = geh & pel & per_lo;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_d           = r_q;
        r_d.ext0_prev = ext0_s;
        r_d.rdata     = 8'h00;

        // Flags follow events regardless of enables; set beats software clear
        if (wr_in) begin
            case (addr_in)
                `TLIC_OFS_CTRL0: begin
                    r_d.ctrl0 = wdata_in;
                end
                `TLIC_OFS_CTRL1: begin
                    r_d.ctrl1 = wdata_in;
                end
                `TLIC_OFS_CTRL2: begin
                    r_d.ctrl2 = wdata_in;
                end
                `TLIC_OFS_RSTCTL: begin
                    r_d.rstctl = wdata_in;
                end
                `TLIC_OFS_IRQ_MASK: begin
                    r_d.mask = wdata_in[1:0];
                end
                default: begin
                    for (int b = 0; b < NB; b++) begin
                        if (bank_hit(addr_in, `TLIC_OFS_FLAG0, b)) begin
                            r_d.flag[b*8 +: 8] = wdata_in;
                        end
                        if (bank_hit(addr_in, `TLIC_OFS_ENA0, b)) begin
                            r_d.ena[b*8 +: 8] = wdata_in;
                        end
                        if (bank_hit(addr_in, `TLIC_OFS_PRIO0, b)) begin
                            r_d.prio[b*8 +: 8] = wdata_in;
                        end
                    end
                end
            endcase
        end

        // Event capture after software write so an event is never lost
        r_d.flag = r_d.flag | periph_event_in;
        if (ext0_s && !r_q.ext0_prev) begin
            r_d.ctrl0[`TLIC_BIT_EXT0_FLAG] = 1'b1;
        end

        // Read port; one cycle latency
        if (rd_in) begin
            case (addr_in)
                `TLIC_OFS_CTRL0:    r_d.rdata = r_q.ctrl0;
                `TLIC_OFS_CTRL1:    r_d.rdata = r_q.ctrl1;
                `TLIC_OFS_CTRL2:    r_d.rdata = r_q.ctrl2;
                `TLIC_OFS_RSTCTL:   r_d.rdata = r_q.rstctl;
                `TLIC_OFS_IRQ_STAT: r_d.rdata = {6'h00, r_q.stat};
                `TLIC_OFS_IRQ_MASK: r_d.rdata = {6'h00, r_q.mask};
                default: begin
                    for (int b = 0; b < NB; b++) begin
                        if (bank_hit(addr_in, `TLIC_OFS_FLAG0, b)) r_d.rdata = r_q.flag[b*8 +: 8];
                        if (bank_hit(addr_in, `TLIC_OFS_ENA0, b))  r_d.rdata = r_q.ena[b*8 +: 8];
                        if (bank_hit(addr_in, `TLIC_OFS_PRIO0, b)) r_d.rdata = r_q.prio[b*8 +: 8];
                    end
                end
            endcase
            if (addr_in == `TLIC_OFS_IRQ_STAT) begin
                r_d.stat = 2'b00;
            end
        end

        // Vector request: high wins and may preempt a low service
        if (!r_q.req) begin
            if (elig_hi && r_q.svc != tlic_pkg::TLIC_HIGH) begin
                r_d.req      = 1'b1;
                r_d.req_high = 1'b1;
                r_d.vec      = `TLIC_VEC_HIGH;
            end else if (elig_lo && r_q.svc == tlic_pkg::TLIC_IDLE) begin
                r_d.req      = 1'b1;
                r_d.req_high = 1'b0;
                r_d.vec      = `TLIC_VEC_LOW;
            end
        end else if (vec_ack_in) begin
            r_d.req = 1'b0;
            if (r_q.req_high) begin
                // Remember a cut-into low service so the high return lands back on it
                r_d.lo_hold = (r_q.svc == tlic_pkg::TLIC_LOW);
                r_d.ctrl0[`TLIC_BIT_GEH] = 1'b0;
                r_d.svc  = tlic_pkg::TLIC_HIGH;
                r_d.stat = r_d.stat | 2'b01;
            end else begin
                r_d.ctrl0[`TLIC_BIT_PEL] = 1'b0;
                r_d.svc  = tlic_pkg::TLIC_LOW;
                r_d.stat = r_d.stat | 2'b10;
            end
        end

        // Return re-enables the level being left; a low service cut by a high one
        // needs the nesting bit to get its own low global back later
        if (retirq_in && !r_q.req) begin
            if (r_q.svc == tlic_pkg::TLIC_LOW && pse) begin
                r_d.ctrl0[`TLIC_BIT_PEL] = 1'b1;
                r_d.svc = tlic_pkg::TLIC_IDLE;
            end else begin
                r_d.ctrl0[`TLIC_BIT_GEH] = 1'b1;
                r_d.lo_hold = 1'b0;
                if (r_q.lo_hold) begin
                    r_d.svc = tlic_pkg::TLIC_LOW;
                end else begin
                    r_d.svc = tlic_pkg::TLIC_IDLE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            r_q        <= '0;
            r_q.prio   <= {NB{`TLIC_RST_PRIO}};
            r_q.rstctl <= `TLIC_RST_BYTE;
            r_q.svc    <= tlic_pkg::TLIC_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    assign rdata_out    = r_q.rdata;
    assign vec_req_out  = r_q.req;
    assign vec_addr_out = r_q.vec;
    assign irq_out      = |(r_q.stat & r_q.mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_compat_vector: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (vec_req_out && !pse) |-> vec_addr_out == `TLIC_VEC_HIGH)
        else $error("compat vector not 0008h");
    a_low_vector: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (vec_req_out && !r_q.req_high) |-> vec_addr_out == `TLIC_VEC_LOW)
        else $error("low vector wrong");
    a_geh_blocks: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!geh && !r_q.req) |=> !vec_req_out)
        else $error("request with global clear");
    a_hi_first: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!r_q.req && elig_hi && r_q.svc != tlic_pkg::TLIC_HIGH) |=> (vec_req_out && r_q.req_high))
        else $error("high not first");
    a_no_low_in_hi: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (r_q.svc == tlic_pkg::TLIC_HIGH && !r_q.req) |=> !(vec_req_out && !r_q.req_high))
        else $error("low during high service");
    a_ack_clears: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (vec_req_out && vec_ack_in && r_q.req_high) |=> !geh)
        else $error("global not cleared");
    a_flag_sets: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (periph_event_in != '0) |=> ((r_q.flag & $past(periph_event_in)) == $past(periph_event_in)))
        else $error("flag missed");
    a_ret_sets: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (retirq_in && !r_q.req && r_q.svc == tlic_pkg::TLIC_HIGH) |=> geh)
        else $error("return did not re-enable");
    a_low_gated: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (pse && !pel && !r_q.req) |=> !(vec_req_out && !r_q.req_high))
        else $error("low passed gate");

    // Named steps of the vector handshake and of a return
    sequence s_hi_taken;
        vec_req_out && vec_ack_in && r_q.req_high;
    endsequence
    sequence s_ret_seen;
        retirq_in && !r_q.req;
    endsequence

    // Handshake: the core must see one steady vector until it takes it
    a_req_holds: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (vec_req_out && !vec_ack_in) |=> (vec_req_out && $stable(vec_addr_out)))
        else $error("request moved before ack");
    a_req_drops: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (vec_req_out && vec_ack_in) |=> !vec_req_out)
        else $error("request stood after ack");
    a_vec_legal: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        vec_req_out |-> (vec_addr_out == `TLIC_VEC_HIGH || vec_addr_out == `TLIC_VEC_LOW))
        else $error("vector outside the two entries");
    a_rdata_quiet: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!rd_in) |=> (rdata_out == 8'h00))
        else $error("read data without a read");
    // Gating by the enables, one-level mode and the pin-zero source
    a_ena_gate: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!r_q.req && !ext0_pend && ((r_q.flag & r_q.ena) == '0)) |=> !vec_req_out)
        else $error("request with no enabled flag");
    a_compat_one_level: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!pse && !r_q.req) |=> !(vec_req_out && !r_q.req_high))
        else $error("low level in compatibility mode");
    a_compat_periph_gate: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!pse && !pel && !ext0_pend && !r_q.req) |=> !vec_req_out)
        else $error("peripheral passed a clear gate");
    a_pin_high: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!r_q.req && geh && ext0_pend && r_q.svc != tlic_pkg::TLIC_HIGH) |=> (vec_req_out && r_q.req_high))
        else $error("pin-zero not high");
    a_ext0_flag: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (ext0_s && !r_q.ext0_prev) |=> r_q.ctrl0[`TLIC_BIT_EXT0_FLAG])
        else $error("pin-zero flag missed");
    // Service levels and returns
    a_stat_set_hi: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        s_hi_taken |=> r_q.stat[0])
        else $error("high accept not recorded");
    a_low_ack_clears: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (vec_req_out && vec_ack_in && !r_q.req_high) |=> (!pel && r_q.stat[1]))
        else $error("low accept not handled");
    a_ret_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (s_ret_seen ##0 (pse && r_q.svc == tlic_pkg::TLIC_LOW)) |=> pel)
        else $error("return did not re-enable low");
    a_low_resumes: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (s_hi_taken ##0 (r_q.svc == tlic_pkg::TLIC_LOW)) |=> (r_q.svc == tlic_pkg::TLIC_HIGH && r_q.lo_hold))
        else $error("preempted low not remembered");
    a_nest_back: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (s_ret_seen ##0 (r_q.svc == tlic_pkg::TLIC_HIGH && r_q.lo_hold)) |=> (r_q.svc == tlic_pkg::TLIC_LOW && geh))
        else $error("nested return lost the low level");
endmodule

// ===== tlic_params.svh
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH

// Register index map (one 8-bit register per index)
`define TLIC_ADDR_W          5
`define TLIC_OFS_CTRL0       5'h00
`define TLIC_OFS_CTRL1       5'h01
`define TLIC_OFS_CTRL2       5'h02
`define TLIC_OFS_FLAG0       5'h03
`define TLIC_OFS_ENA0        5'h08
`define TLIC_OFS_PRIO0       5'h0d
`define TLIC_OFS_RSTCTL      5'h12
`define TLIC_OFS_IRQ_STAT    5'h13
`define TLIC_OFS_IRQ_MASK    5'h14
`define TLIC_BANKS           5

// Field positions in control register 0
`define TLIC_BIT_GEH         7
`define TLIC_BIT_PEL         6
`define TLIC_BIT_EXT0_EN     4
`define TLIC_BIT_EXT0_FLAG   1
// Field position in reset control register
`define TLIC_BIT_PSE         7

// Reset values
`define TLIC_RST_BYTE        8'h00
`define TLIC_RST_PRIO        8'hff

// Vector addresses
`define TLIC_VEC_HIGH        16'h0008
`define TLIC_VEC_LOW         16'h0018

`endif

// ===== tlic_pkg.sv
package tlic_pkg;
    typedef enum logic [2:0] {
        TLIC_IDLE = 3'b001,
        TLIC_LOW  = 3'b010,
        TLIC_HIGH = 3'b100
    } tlic_svc_t;

    typedef logic [7:0] tlic_byte_t;
endpackage

// ===== tlic_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a vector of asynchronous event pins
module tlic_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tlic_sync_t;

    tlic_sync_t r_q;
    tlic_sync_t r_d;

    // First stage feeds only the second stage
    always_comb begin
        r_d    = r_q;
        r_d.s1 = async_in;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign sync_out = r_q.s2;
endmodule

// ===== tlic_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core side: takes vectors, issues returns
// ----------------------------------------
module tlic_core_model (
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        vec_req_in,
    input  wire logic [15:0] vec_addr_in,
    input  wire logic [3:0]  ack_dly_in,
    input  wire logic        ret_cmd_in,
    output logic             vec_ack_out,
    output logic             retirq_out,
    output logic [15:0]      last_vec_out,
    output logic [7:0]       n_acc_out
);
    logic [3:0] wait_q;

    // Ack after a chosen stall; the ack drops at once so one vector is taken once
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            vec_ack_out  <= 1'b0;
            retirq_out   <= 1'b0;
            last_vec_out <= 16'h0000;
            n_acc_out    <= 8'h00;
            wait_q       <= 4'h0;
        end else begin
            retirq_out <= ret_cmd_in; // Return pulse
            if (vec_ack_out) begin
                vec_ack_out <= 1'b0;
                wait_q      <= 4'h0;
            end else if (vec_req_in && wait_q >= ack_dly_in) begin
                vec_ack_out  <= 1'b1; // Branch taken
                last_vec_out <= vec_addr_in;
                n_acc_out    <= n_acc_out + 8'h01;
            end else if (vec_req_in) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "tlic_params.svh"
module tb;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        sys_clk, resetn, wr, rd, ext0, ack, ret, ret_cmd, vreq, irq;
    logic [4:0]  addr;
    logic [7:0]  wdata, rdata, n_acc;
    logic [39:0] ev, flags, ena, pri;
    logic [15:0] vaddr, last_vec;
    logic [3:0]  dly;
    logic [31:0] seed;
    int          n_mismatch, n_tests, cyc, hs, ls;

    tlic_ctrl tlic_ctrl_inst (
        .sys_clk_in      (sys_clk),
        .resetn_in       (resetn),
        .addr_in         (addr),
        .wdata_in        (wdata),
        .wr_in           (wr),
        .rd_in           (rd),
        .rdata_out       (rdata),
        .ext0_pin_in     (ext0),
        .periph_event_in (ev),
        .vec_ack_in      (ack),
        .retirq_in       (ret),
        .vec_req_out     (vreq),
        .vec_addr_out    (vaddr),
        .irq_out         (irq)
    );
    tlic_core_model tlic_core_model_inst (
        .sys_clk_in   (sys_clk),
        .resetn_in    (resetn),
        .vec_req_in   (vreq),
        .vec_addr_in  (vaddr),
        .ack_dly_in   (dly),
        .ret_cmd_in   (ret_cmd),
        .vec_ack_out  (ack),
        .retirq_out   (ret),
        .last_vec_out (last_vec),
        .n_acc_out    (n_acc)
    );

    // 50 MHz clock and a hang guard well above the run length
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Expectations, bus cycles and checks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] exp_vec(input logic high);
        return high ? 16'h0008 : 16'h0018;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk("register", {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic pulse(input logic [39:0] m);
        seed = xs(seed);
        @(posedge sys_clk);
        ev    <= m;
        dly   <= {1'b0, seed[2:0]};
        flags = flags | m;
        @(posedge sys_clk);
        ev <= '0;
    endtask
    // Software clears one flag and leaves its bank neighbours alone
    task automatic clr(input int s);
        flags[s] = 1'b0;
        wr_reg(5'(`TLIC_OFS_FLAG0 + s / 8), flags[s / 8 * 8 +: 8]);
    endtask
    task automatic ret_irq();
        @(posedge sys_clk);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_vec(input logic high);
        logic [7:0] n0;
        n0 = n_acc;
        for (int i = 0; i < 40 && n_acc == n0; i++)
            @(posedge sys_clk);
        #1 chk("vector", exp_vec(high), (n_acc == n0) ? 16'hdead : last_vec);
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic no_vec(input int n);
        logic [7:0] n0;
        n0 = n_acc;
        repeat (n) @(posedge sys_clk);
        #1 chk("quiet", {n0, 8'h00}, {n_acc, 7'h00, vreq});
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {resetn, wr, rd, ext0, ret_cmd} = 5'h00;
        {addr, wdata, ev, flags, dly, cyc, n_mismatch, n_tests} = '0;
        seed = 32'd56;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 22; a++)
            chk_rd(5'(a), (a >= 13 && a <= 17) ? 8'hff : 8'h00);
        wr_reg(`TLIC_OFS_IRQ_MASK, 8'h01);
        seed = xs(seed);
        hs = seed % 40;
        seed = xs(seed);
        ls = (hs + 1 + seed % 39) % 40;
        // Flag sets with every enable off, yet no branch follows
        pulse(40'h1 << ls);
        chk_rd(5'(`TLIC_OFS_FLAG0 + ls / 8), flags[ls / 8 * 8 +: 8]);
        no_vec(20);
        // Single-level mode: both globals needed for a peripheral, priority bit ignored
        wr_reg(5'(`TLIC_OFS_ENA0 + ls / 8), 8'(8'h01 << (ls % 8)));
        wr_reg(5'(`TLIC_OFS_PRIO0 + ls / 8), 8'h00);
        wr_reg(`TLIC_OFS_CTRL0, 8'h80);
        no_vec(20);
        wr_reg(`TLIC_OFS_CTRL0, 8'h40);
        no_vec(20);
        wr_reg(`TLIC_OFS_CTRL0, 8'hc0);
        wait_vec(1'b1);
        chk_rd(`TLIC_OFS_CTRL0, 8'h40);
        chk("irq", 16'h0001, {15'h0000, irq});
        chk_rd(`TLIC_OFS_IRQ_STAT, 8'h01);
        chk("irq", 16'h0000, {15'h0000, irq});
        clr(ls);
        ret_irq();
        chk_rd(`TLIC_OFS_CTRL0, 8'hc0);
        // Pin-zero source needs only the high global
        wr_reg(`TLIC_OFS_CTRL0, 8'h90);
        @(posedge sys_clk);
        ext0 <= 1'b1;
        wait_vec(1'b1);
        ext0 <= 1'b0;
        wr_reg(`TLIC_OFS_CTRL0, 8'h10);
        ret_irq();
        chk_rd(`TLIC_OFS_IRQ_STAT, 8'h01);
        // Two-level mode with one high and one low source
        wr_reg(`TLIC_OFS_CTRL0, 8'h40);
        wr_reg(`TLIC_OFS_RSTCTL, 8'h80);
        ena = (40'h1 << hs) | (40'h1 << ls);
        pri = 40'h1 << hs;
        for (int b = 0; b < 5; b++) begin
            wr_reg(5'(`TLIC_OFS_ENA0 + b), ena[b * 8 +: 8]);
            wr_reg(5'(`TLIC_OFS_PRIO0 + b), pri[b * 8 +: 8]);
        end
        pulse((40'h1 << hs) | (40'h1 << ls));
        no_vec(20);
        wr_reg(`TLIC_OFS_CTRL0, 8'hc0);
        wait_vec(1'b1);
        chk_rd(`TLIC_OFS_CTRL0, 8'h40);
        // Both globals on again: only the running high service holds the low source off
        wr_reg(`TLIC_OFS_CTRL0, 8'hc0);
        no_vec(20);
        wr_reg(`TLIC_OFS_CTRL0, 8'h40);
        clr(hs);
        ret_irq();
        wait_vec(1'b0);
        chk_rd(`TLIC_OFS_CTRL0, 8'h80);
        chk("irq", 16'h0001, {15'h0000, irq});
        chk_rd(`TLIC_OFS_IRQ_STAT, 8'h03);
        // High event preempts the low service
        pulse(40'h1 << hs);
        wait_vec(1'b1);
        clr(hs);
        ret_irq();
        clr(ls);
        ret_irq();
        chk_rd(`TLIC_OFS_CTRL0, 8'hc0);
        // Low global off holds the low source; then its own enable is cleared
        wr_reg(`TLIC_OFS_CTRL0, 8'h80);
        pulse(40'h1 << ls);
        no_vec(20);
        ena[ls] = 1'b0;
        wr_reg(5'(`TLIC_OFS_ENA0 + ls / 8), ena[ls / 8 * 8 +: 8]);
        wr_reg(`TLIC_OFS_CTRL0, 8'hc0);
        no_vec(20);
        pulse(40'h1 << hs);
        wait_vec(1'b1);
        give_verdict();
    end
endmodule
